// ---- hw/fdq_defines.svh ----
// timing constants and comparator bit positions of the fault diagnosis sequencer
// Function
// - Rising enable or falling inverted enable clears the latched low fault flag.
// - Supply, thermal or over-current faults run regeneration before outputs go high-Z.
// - Regeneration is low-side (both N switches) or high-side (both P switches).
// - Short to supply uses high-side regeneration; every other cause uses low-side.
// - Logic-supply power-on undervoltage skips regeneration, outputs straight to high-Z.
// - Simultaneous high-side and low-side over-current turns every switch off.
// - Diagnosis switches comparator thresholds and checks normal and abnormal responses.
// - Diagnosis starts at power-up or when enable pins change to disabled.
// - Initial diagnosis waits until all three comparators report undetected.
// - Restart diagnosis needs disabled state and all comparators undetected.
// - Both diagnosis kinds last about 80 microseconds.
// - During diagnosis enables are ignored, outputs high-Z, fault flag low.
// - Result shows on fault flag once enabled: high pass, low fail.
// - Failing result latches until power-on reset or a new restart diagnosis.
// - Threshold select high picks diagnosis threshold, low picks normal threshold.
// - Three tests: normal, changed, normal; failures still leave outputs functional.
// - Diagnosis never starting reports abnormal and keeps outputs high-Z.
// - Over-current restart is one enable falling or inverted enable rising pulse.
`ifndef FDQ_DEFINES_SVH
`define FDQ_DEFINES_SVH

`define FDQ_CLK_MHZ        250
`define FDQ_FAULT_FLAG_N_TIME_NS   80000
`define FDQ_FAULT_FLAG_N_CYCLES    ((`FDQ_FAULT_FLAG_N_TIME_NS * `FDQ_CLK_MHZ) / 1000)
`define FDQ_REGEN_TIME_NS  2000
`define FDQ_REGEN_CYCLES   ((`FDQ_REGEN_TIME_NS * `FDQ_CLK_MHZ) / 1000)
`define FDQ_START_TIMEOUT  1000000
`define FDQ_CMP_BATT_UV    0
`define FDQ_CMP_LOGIC_UV   1
`define FDQ_CMP_LOGIC_OV   2

`endif

// ---- hw/fdq_pkg.sv ----
// types shared by the fault diagnosis sequencer
package fdq_pkg;

	// gate drive of one half bridge
	typedef struct packed {
		logic highOn;
		logic lowOn;
	} fdq_leg_s;

	// fault detector inputs
	typedef struct packed {
		logic battUv;
		logic logicUv;
		logic logicOv;
		logic thermalShutdown;
		logic ocHigh;
		logic ocLow;
		logic shortToSupply;
	} fdq_fault_s;

	typedef enum logic [1:0] {
		FDQ_TEST_NORM1,
		FDQ_TEST_CHANGED,
		FDQ_TEST_NORM2
	} fdq_test_e;

endpackage

// ---- hw/fdq_sync.sv ----
// two-flop synchroniser for a bus of pin levels
`timescale 1ns/100ps
module fdq_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_sys,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] stage1;

	// first stage only feeds the second
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			stage1 <= '0;
			dout   <= '0;
		end else begin
			stage1 <= din;
			dout   <= stage1;
		end
	end
endmodule

// ---- hw/fdq_sequencer.sv ----
// protection and self-diagnosis sequencer of an h-bridge driver
`timescale 1ns/100ps
`include "fdq_defines.svh"
module fdq_sequencer #(
	parameter int FAULT_FLAG_N_CYCLES   = `FDQ_FAULT_FLAG_N_CYCLES,
	parameter int REGEN_CYCLES  = `FDQ_REGEN_CYCLES,
	parameter int START_TIMEOUT = `FDQ_START_TIMEOUT
) (
	input  wire logic              clk_sys,
	input  wire logic              sys_rst,
	input  wire logic              por_n,
	input  wire logic              drive_enable,
	input  wire logic              drive_enable_inv,
	input  wire fdq_pkg::fdq_leg_s cmdA,
	input  wire fdq_pkg::fdq_leg_s cmdB,
	input  wire fdq_pkg::fdq_fault_s faults,
	input  wire logic [2:0]        cmpDetect,
	output fdq_pkg::fdq_leg_s      bridge_out_a,
	output fdq_pkg::fdq_leg_s      bridge_out_b,
	output logic [2:0]             thresholdSel,
	output logic                   fault_flag_n,
	output logic                   diagBusy
);
	// ------------------------------------------------------------
	// input synchronisation
	// ------------------------------------------------------------
	localparam int NIN = 13;
	logic [NIN-1:0]      rawIn;
	logic [NIN-1:0]      syncIn;
	logic                porN;
	logic                en;
	logic                enInv;
	fdq_pkg::fdq_fault_s flt;
	logic [2:0]          cmp;

	assign rawIn = {por_n, drive_enable, drive_enable_inv, faults, cmpDetect};

	fdq_sync #(.WIDTH(NIN)) uSync (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.din     (rawIn),
		.dout    (syncIn)
	);

	assign porN  = syncIn[12];
	assign en    = syncIn[11];
	assign enInv = syncIn[10];
	assign flt   = fdq_pkg::fdq_fault_s'(syncIn[9:3]);
	assign cmp   = syncIn[2:0];

	// ------------------------------------------------------------
	// enable edge detection
	// ------------------------------------------------------------
	logic enD;
	logic enInvD;
	logic enabled;
	logic enabledD;
	logic clearEdge;
	logic disableEdge;

	assign enabled = en && !enInv;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			enD      <= 1'b0;
			enInvD   <= 1'b1;
			enabledD <= 1'b0;
		end else begin
			enD      <= en;
			enInvD   <= enInv;
			enabledD <= enabled;
		end
	end

	// rising enable or falling inverted enable
	assign clearEdge   = (en && !enD) || (!enInv && enInvD);
	// enabled pair drops to disabled pair
	assign disableEdge = enabledD && !en && enInv;

	// ------------------------------------------------------------
	// diagnosis sequencer
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_POR,
		ST_WAIT_INIT,
		ST_WAIT_RESTART,
		ST_TEST,
		ST_IDLE
	} st_e;

	st_e               state;
	fdq_pkg::fdq_test_e test;
	logic [31:0]       tick;
	logic [31:0]       waitCnt;
	logic              diagFail;
	logic              neverStarted;
	logic              allClear;
	logic              sampleNow;

	localparam int PHASE = FAULT_FLAG_N_CYCLES / 3;

	assign allClear  = (cmp == 3'h0);
	assign sampleNow = (tick == 32'(PHASE - 1));

	// expected comparator response for a test phase
	function automatic logic [2:0] expectCmp(fdq_pkg::fdq_test_e t);
		expectCmp = (t == fdq_pkg::FDQ_TEST_CHANGED) ? 3'h7 : 3'h0;
	endfunction

	always_ff @(posedge clk_sys) begin
		if (sys_rst || !porN) begin
			state        <= ST_POR;
			test         <= fdq_pkg::FDQ_TEST_NORM1;
			tick         <= 32'h0;
			waitCnt      <= 32'h0;
			diagFail     <= 1'b0;
			neverStarted <= 1'b0;
		end else begin
			case (state)
				ST_POR: begin
					state   <= ST_WAIT_INIT;
					waitCnt <= 32'h0;
				end
				ST_WAIT_INIT: begin
					// hold off while supplies are still ramping
					if (allClear) begin
						state        <= ST_TEST;
						test         <= fdq_pkg::FDQ_TEST_NORM1;
						tick         <= 32'h0;
						diagFail     <= 1'b0;
						neverStarted <= 1'b0;
					end else if (waitCnt == 32'(START_TIMEOUT)) begin
						neverStarted <= 1'b1;
					end else begin
						waitCnt <= waitCnt + 32'h1;
					end
				end
				ST_WAIT_RESTART: begin
					if (allClear && !enabled) begin
						state    <= ST_TEST;
						test     <= fdq_pkg::FDQ_TEST_NORM1;
						tick     <= 32'h0;
						diagFail <= 1'b0;
					end else if (enabled) begin
						state <= ST_IDLE;
					end
				end
				ST_TEST: begin
					// three phases of FAULT_FLAG_N_CYCLES / 3 cycles each, rounded down, make up the diagnosis time
					tick <= sampleNow ? 32'h0 : tick + 32'h1;
					if (sampleNow) begin
						if (cmp != expectCmp(test)) begin
							diagFail <= 1'b1;
						end
						case (test)
							fdq_pkg::FDQ_TEST_NORM1:
								test <= fdq_pkg::FDQ_TEST_CHANGED;
							fdq_pkg::FDQ_TEST_CHANGED:
								test <= fdq_pkg::FDQ_TEST_NORM2;
							default: begin
								test  <= fdq_pkg::FDQ_TEST_NORM1;
								state <= ST_IDLE;
							end
						endcase
					end
				end
				ST_IDLE: begin
					if (disableEdge) begin
						state <= ST_WAIT_RESTART;
					end
				end
				default: state <= ST_POR;
			endcase
		end
	end

	// ------------------------------------------------------------
	// threshold select
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			thresholdSel <= 3'h0;
		end else if (state == ST_TEST && test == fdq_pkg::FDQ_TEST_CHANGED) begin
			thresholdSel <= 3'h7;
		end else begin
			thresholdSel <= 3'h0;
		end
	end

	logic inDiag;
	assign inDiag = (state != ST_IDLE);

	// ------------------------------------------------------------
	// protection fault latch and regeneration
	// ------------------------------------------------------------
	logic        protFault;
	logic        protLatch;
	logic        regenHigh;
	logic        allOff;
	logic [31:0] regenCnt;
	logic        regenActive;
	logic        latchedKind;

	// thermal and over-current are masked during diagnosis
	assign protFault = flt.battUv || flt.logicUv || flt.logicOv ||
		(!inDiag && (flt.thermalShutdown || flt.ocHigh || flt.ocLow));

	always_ff @(posedge clk_sys) begin
		if (sys_rst || !porN) begin
			protLatch   <= 1'b0;
			regenHigh   <= 1'b0;
			allOff      <= 1'b0;
			regenCnt    <= 32'h0;
			regenActive <= 1'b0;
		end else if (protFault && !protLatch) begin
			protLatch   <= 1'b1;
			regenHigh   <= flt.shortToSupply;
			allOff      <= flt.ocHigh && flt.ocLow;
			regenActive <= !(flt.ocHigh && flt.ocLow);
			regenCnt    <= 32'h0;
		end else begin
			if (regenActive) begin
				// regeneration length is a parameter
				if (regenCnt == 32'(REGEN_CYCLES - 1)) begin
					regenActive <= 1'b0;
				end
				regenCnt <= regenCnt + 32'h1;
			end
			// supply faults recover by themselves, latched ones by edge
			if (protLatch && !protFault && !regenActive &&
				(clearEdge || !(flt.thermalShutdown || flt.ocHigh ||
				flt.ocLow) && !latchedKind)) begin
				protLatch <= 1'b0;
				allOff    <= 1'b0;
			end
		end
	end

	// thermal and over-current latch until an enable edge
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !porN) begin
			latchedKind <= 1'b0;
		end else if (!inDiag &&
			(flt.thermalShutdown || flt.ocHigh || flt.ocLow)) begin
			latchedKind <= 1'b1;
		end else if (clearEdge) begin
			latchedKind <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// bridge drive and fault flag
	// ------------------------------------------------------------
	fdq_pkg::fdq_leg_s next_a;
	fdq_pkg::fdq_leg_s next_b;
	logic              next_flag;

	always_comb begin
		next_a = cmdA;
		next_b = cmdB;
		if (!porN || inDiag || neverStarted) begin
			next_a = '0;
			next_b = '0;
		end else if (protLatch && regenActive) begin
			next_a = regenHigh ? 2'b10 : 2'b01;
			next_b = regenHigh ? 2'b10 : 2'b01;
		end else if (protLatch || allOff || !enabled) begin
			next_a = '0;
			next_b = '0;
		end
	end

	always_comb begin
		if (inDiag || neverStarted) begin
			next_flag = 1'b0;
		end else if (diagFail || protLatch) begin
			next_flag = 1'b0;
		end else begin
			next_flag = enabled;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			bridge_out_a <= '0;
			bridge_out_b <= '0;
			fault_flag_n <= 1'b0;
			diagBusy     <= 1'b1;
		end else begin
			bridge_out_a <= next_a;
			bridge_out_b <= next_b;
			fault_flag_n <= next_flag;
			diagBusy     <= inDiag;
		end
	end
endmodule

// ---- dv/fdq_seq_properties.sv ----
// port assertions of the fault diagnosis sequencer
`timescale 1ns/100ps
module fdq_seq_properties (
	input	wire logic		clk_sys,
	input	wire logic		sys_rst,
	input	wire logic		por_n,
	input	wire fdq_pkg::fdq_fault_s	faults,
	input	wire fdq_pkg::fdq_leg_s	bridge_out_a,
	input	wire fdq_pkg::fdq_leg_s	bridge_out_b,
	input	wire logic [2:0]	thresholdSel,
	input	wire logic		fault_flag_n,
	input	wire logic		diagBusy
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// both legs off
	wire hiZ = {bridge_out_a, bridge_out_b} == 4'h0;

	// diagnosis holds outputs off and flag low
	chk_busy_hiz: assert property (diagBusy |-> hiZ)
		else $error("outputs driven while busy");
	chk_busy_flag: assert property (diagBusy |-> !fault_flag_n)
		else $error("flag high while busy");
	// thresholds move only together and only in diagnosis
	chk_thr_busy: assert property (thresholdSel != 3'h0 |-> diagBusy)
		else $error("threshold changed outside diagnosis");
	chk_thr_all: assert property (thresholdSel == 3'h0 || thresholdSel == 3'h7)
		else $error("thresholds split");
	// test order: normal, changed, normal
	chk_thr_hold: assert property ($rose(thresholdSel[0]) |-> thresholdSel[0][*8])
		else $error("changed test too short");
	chk_thr_late: assert property ($rose(thresholdSel[0]) |-> $past(diagBusy, 8))
		else $error("changed test without first test");
	chk_t3_follows: assert property ($fell(thresholdSel[0]) |-> diagBusy[*8])
		else $error("third test missing");
	// protection shutdowns
	chk_dual_oc: assert property ((faults.ocHigh && faults.ocLow)[*5] |-> hiZ)
		else $error("switch on under dual over-current");
	chk_por_hiz: assert property ((!por_n)[*5] |-> hiZ && diagBusy)
		else $error("outputs driven in power-on reset");
	// main scenarios
	cover property ($rose(thresholdSel[0]));
	cover property ($fell(diagBusy));
	cover property (faults.ocHigh && faults.ocLow && hiZ);
endmodule
bind fdq_sequencer fdq_seq_properties u_fdq_seq_properties (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .por_n(por_n), .faults(faults),
	.bridge_out_a(bridge_out_a), .bridge_out_b(bridge_out_b),
	.thresholdSel(thresholdSel), .fault_flag_n(fault_flag_n),
	.diagBusy(diagBusy)
);

// ---- dv/fdq_mcu_model.sv ----
// controller model driving the complementary enable pins
`timescale 1ns/100ps
module fdq_mcu_model (
	input	wire logic	enReq,
	output	logic		drive_enable,
	output	logic		drive_enable_inv
);
	// pins always complementary, following the bench request
	assign drive_enable = enReq;
	assign drive_enable_inv = ~enReq;
endmodule

// ---- dv/fdq_sequencer_test.sv ----
// self-checking bench of the fault diagnosis sequencer
`timescale 1ns/100ps
module fdq_sequencer_test;
	localparam int FAULT_FLAG_N = 30;
	localparam int REGEN = 4;
	logic	clk_sys = 1'b0;
	logic	sys_rst = 1'b1;
	logic	por_n = 1'b1;
	logic	enReq = 1'b1;
	logic	ramp = 1'b1;
	logic	drive_enable;
	logic	drive_enable_inv;
	logic	fault_flag_n;
	logic	diagBusy;
	logic [1:0]	f;
	logic [2:0]	cmpDetect = 3'h7;
	logic [2:0]	errMask = 3'h0;
	logic [2:0]	thresholdSel;
	logic [6:0]	tab[$] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h02, 7'h05, 7'h06};
	fdq_pkg::fdq_leg_s	cmdA = 2'h0;
	fdq_pkg::fdq_leg_s	cmdB = 2'h0;
	fdq_pkg::fdq_leg_s	bridge_out_a;
	fdq_pkg::fdq_leg_s	bridge_out_b;
	fdq_pkg::fdq_fault_s	faults = 7'h00;
	int	n_mismatch = 0;
	int	compares = 0;

	// clock
	always #2 clk_sys = ~clk_sys;
	// comparators: stuck on a slow ramp, else follow threshold minus faults
	always @(negedge clk_sys)
		cmpDetect <= ramp ? 3'h7 : thresholdSel & ~errMask;

	fdq_mcu_model u_fdq_mcu_model (.enReq(enReq), .drive_enable(drive_enable),
		.drive_enable_inv(drive_enable_inv));
	fdq_sequencer #(.FAULT_FLAG_N_CYCLES(FAULT_FLAG_N), .REGEN_CYCLES(REGEN),
		.START_TIMEOUT(50)) u_fdq_sequencer (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .por_n(por_n), .drive_enable(drive_enable),
		.drive_enable_inv(drive_enable_inv), .cmdA(cmdA), .cmdB(cmdB),
		.faults(faults), .cmpDetect(cmpDetect), .bridge_out_a(bridge_out_a),
		.bridge_out_b(bridge_out_b), .thresholdSel(thresholdSel),
		.fault_flag_n(fault_flag_n), .diagBusy(diagBusy));

	task automatic chk_out(input logic [3:0] exp);
		compares++;
		if ({bridge_out_a, bridge_out_b} !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: outputs %h", $time, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string s);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: %s", $time, s);
		end
	endtask

	task automatic chk_follow;
		cmdA = fdq_pkg::fdq_leg_s'(2'h1 << $urandom_range(1));
		cmdB = fdq_pkg::fdq_leg_s'(2'h1 << $urandom_range(1));
		repeat (5) @(negedge clk_sys);
		chk_out({cmdA, cmdB});
	endtask

	// wait out a diagnosis, enable and read the result
	task automatic run_fault_flag_n(input logic [2:0] mask);
		int n;
		errMask = mask;
		for (n = 0; n < 200 && diagBusy !== 1'b1; n++)
			@(negedge clk_sys);
		for (n = 0; n < 200 && diagBusy === 1'b1; n++)
			@(negedge clk_sys);
		chk_bit(n >= FAULT_FLAG_N && n <= FAULT_FLAG_N + 8, 1'b1, "fault_flag_n length");
		enReq = 1'b1;
		repeat (6) @(negedge clk_sys);
		chk_bit(fault_flag_n, mask == 3'h0, "fault_flag_n result");
		$display("test diagnosis done at %0t", $time);
	endtask

	task automatic end_sim;
		$display("compares %0d, mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// main sequence
	initial begin
		void'($urandom(32'hBBBD));
		repeat (5) @(negedge clk_sys);
		sys_rst = 1'b0;
		repeat (60) @(negedge clk_sys);
		chk_bit(diagBusy, 1'b1, "ramp wait");
		chk_bit(fault_flag_n, 1'b0, "ramp flag");
		chk_out(4'h0);
		ramp = 1'b0;
		run_fault_flag_n(3'h0);
		chk_follow();
		enReq = 1'b0;
		run_fault_flag_n(3'(1 << $urandom_range(2)));
		chk_follow();
		por_n = 1'b0;
		repeat (6) @(negedge clk_sys);
		chk_out(4'h0);
		por_n = 1'b1;
		run_fault_flag_n(3'h0);
		enReq = 1'b0;
		run_fault_flag_n(3'h0);
		foreach (tab[k]) begin
			chk_follow();
			faults = tab[k];
			f = tab[k] == 7'h06 ? 2'h0 : {tab[k][0], ~tab[k][0]};
			repeat (4) @(negedge clk_sys);
			chk_out({f, f});
			repeat (REGEN + 2) @(negedge clk_sys);
			chk_out(4'h0);
			chk_bit(fault_flag_n, 1'b0, "fault flag");
			faults = 7'h00;
			if (k > 2) begin
				enReq = 1'b0;
				@(negedge clk_sys);
				enReq = 1'b1;
				repeat (8) @(negedge clk_sys);
				chk_bit(fault_flag_n, 1'b1, "pulse restart");
			end else begin
				repeat (6) @(negedge clk_sys);
				chk_bit(fault_flag_n, 1'b1, "recovery");
			end
		end
		end_sim();
	end

	// watchdog
	initial begin
		#40000;
		n_mismatch++;
		end_sim();
	end
endmodule
